// ---- pin_request_pkg.sv ----
// Package of constants and types for the external pin interrupt request block
//
// Notes on behaviour
// - With the pin enabled, the pull-disable bit switches the internal pull device off.
// - Polarity bit 0 picks falling edges or low levels; 1 picks rising or high.
// - Enabled pin looking for rising edges gets a pull-down.
// - Enabled pin looking for falling edges gets a pull-up.
// - Pin enable bit turns the request pin function on or off.
// - Read-only flag is set by each qualifying event, zero when nothing pends.
// - Writing one to the acknowledge bit clears the flag, level mode permitting.
// - Writing zero to acknowledge does nothing; the bit always reads zero.
// - In edge-and-level mode acknowledge cannot clear while the pin stays asserted.
// - Interrupt enable passes the flag to the processor request; otherwise software polls.
// - Mode bit zero detects selected edges only, ignoring static levels.
// - Mode bit one detects selected edge plus the matching level.
package pin_request_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] STATUS_CONTROL_OFFSET = 4'h0;

    // Field positions within the status and control register
    localparam int unsigned MODE_BIT     = 0;
    localparam int unsigned IE_BIT       = 1;
    localparam int unsigned ACK_BIT      = 2;
    localparam int unsigned FLAG_BIT     = 3;
    localparam int unsigned PIN_EN_BIT   = 4;
    localparam int unsigned POLARITY_BIT = 5;
    localparam int unsigned PULL_DIS_BIT = 6;

    // Values after reset
    localparam logic RESET_CONTROL_BIT = 1'b0;
    localparam logic RESET_FLAG        = 1'b0;
    localparam logic [2:0] RESET_SYNC  = 3'h7;

    // Value read from an unmapped address
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

    // Bus slave answer states
    typedef enum logic [0:0] {
        BUS_IDLE,
        BUS_DONE
    } bus_state_t;

endpackage : pin_request_pkg

// ---- pin_config_if.sv ----
// Interface carrying the configuration bits from the register file to the detector
`timescale 1ns/10ps
`default_nettype none
interface pin_config_if;
    logic pin_enable;
    logic polarity;
    logic level_mode;
    logic ack_pulse;
    logic flag;
    logic pin_asserted;

    modport regs (output pin_enable, output polarity, output level_mode, output ack_pulse,
                  input flag, input pin_asserted);
    modport detect (input pin_enable, input polarity, input level_mode, input ack_pulse,
                    output flag, output pin_asserted);
endinterface : pin_config_if
`default_nettype wire

// ---- pin_event_detect.sv ----
// Synchroniser, edge and level detector and event flag for the request pin
`timescale 1ns/10ps
`default_nettype none
module pin_event_detect
    import pin_request_pkg::*;
(
    // Clock and reset
    input  wire logic   mclk_i,
    input  wire logic   reset_n_i,
    // Raw pin
    input  wire logic   pin_i,
    // Configuration and status
    pin_config_if.detect cfg
);
    import pin_request_pkg::*;

    logic [2:0] sync;
    logic       asserted_now;
    logic       asserted_prev;
    logic       edge_event;
    logic       level_event;
    logic       set_flag;

    ////////////////////////////////////////////////////////////////////////////
    // Three stage synchroniser; stage 0 is read only by stage 1
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync <= RESET_SYNC;
        end else begin
            sync <= {sync[1:0], pin_i};
        end
    end

    // Pin level in asserted sense, taken only when the last two stages agree
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            asserted_now  <= 1'b0;
            asserted_prev <= 1'b0;
        end else begin
            if (sync[2] == sync[1]) begin
                asserted_now <= sync[2] ~^ cfg.polarity;
            end
            asserted_prev <= asserted_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Qualified events; a disabled pin raises nothing
    assign edge_event  = cfg.pin_enable && asserted_now && !asserted_prev;
    assign level_event = cfg.pin_enable && cfg.level_mode && asserted_now;
    assign set_flag    = edge_event || level_event;
    assign cfg.pin_asserted = asserted_now;

    // Event flag; a set in the clearing cycle wins, which also holds it in level mode
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg.flag <= RESET_FLAG;
        end else if (set_flag) begin
            cfg.flag <= 1'b1;
        end else if (cfg.ack_pulse) begin
            cfg.flag <= 1'b0;
        end
    end

endmodule : pin_event_detect
`default_nettype wire

// ---- pin_request_top.sv ----
// Top of the external pin interrupt request block with its Avalon-MM register slave
`timescale 1ns/10ps
`default_nettype none
module pin_request_top
    import pin_request_pkg::*;
(
    // Clock and reset
    input  wire logic                                mclk_i,
    input  wire logic                                reset_n_i,
    // Avalon-MM slave
    input  wire logic [pin_request_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                                avs_read_i,
    input  wire logic                                avs_write_i,
    input  wire logic [pin_request_pkg::DATA_W-1:0]  avs_writedata_i,
    input  wire logic [3:0]                          avs_byteenable_i,
    output logic [pin_request_pkg::DATA_W-1:0]       avs_readdata_o,
    output logic                                     avs_waitrequest_o,
    // Request pin and its pull devices
    input  wire logic                                request_pin_i,
    output logic                                     pull_up_en_o,
    output logic                                     pull_down_en_o,
    // Processor interrupt request
    output logic                                     cpu_request_o
);
    import pin_request_pkg::*;

    pin_config_if cfg ();

    bus_state_t bus_state;
    logic       pull_device_disable;
    logic       edge_polarity_select;
    logic       request_pin_enable;
    logic       request_interrupt_enable;
    logic       detection_mode_select;
    logic       access;
    logic       hit;
    logic       wr_low;
    logic [7:0] status_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; waitrequest drops for one cycle after a request is seen
    assign access            = avs_read_i || avs_write_i;
    assign hit               = avs_address_i == STATUS_CONTROL_OFFSET;
    assign avs_waitrequest_o = access && (bus_state == BUS_IDLE);
    assign wr_low            = avs_write_i && !avs_waitrequest_o && hit && avs_byteenable_i[0];

    // Answer sequencer; one wait cycle gives time for registered read data
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_state <= BUS_IDLE;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (access) begin
                        bus_state <= BUS_DONE;
                    end
                end
                BUS_DONE: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits written by software; only byte lane 0 carries the register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pull_device_disable      <= RESET_CONTROL_BIT;
            edge_polarity_select     <= RESET_CONTROL_BIT;
            request_pin_enable       <= RESET_CONTROL_BIT;
            request_interrupt_enable <= RESET_CONTROL_BIT;
            detection_mode_select    <= RESET_CONTROL_BIT;
        end else if (wr_low) begin
            pull_device_disable      <= avs_writedata_i[PULL_DIS_BIT];
            edge_polarity_select     <= avs_writedata_i[POLARITY_BIT];
            request_pin_enable       <= avs_writedata_i[PIN_EN_BIT];
            request_interrupt_enable <= avs_writedata_i[IE_BIT];
            detection_mode_select    <= avs_writedata_i[MODE_BIT];
        end
    end

    // Acknowledge is a pulse only when a one is written; a zero does nothing
    assign cfg.ack_pulse  = wr_low && avs_writedata_i[ACK_BIT];
    assign cfg.pin_enable = request_pin_enable;
    assign cfg.polarity   = edge_polarity_select;
    assign cfg.level_mode = detection_mode_select;

    ////////////////////////////////////////////////////////////////////////////
    // Read image; acknowledge and bit 7 always read zero
    always_comb begin
        status_byte               = 8'h00;
        status_byte[PULL_DIS_BIT] = pull_device_disable;
        status_byte[POLARITY_BIT] = edge_polarity_select;
        status_byte[PIN_EN_BIT]   = request_pin_enable;
        status_byte[FLAG_BIT]     = cfg.flag;
        status_byte[ACK_BIT]      = 1'b0;
        status_byte[IE_BIT]       = request_interrupt_enable;
        status_byte[MODE_BIT]     = detection_mode_select;
    end

    // Read data registered in the wait cycle so it stands at the answer edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            avs_readdata_o <= UNMAPPED_READ;
        end else if (avs_read_i && bus_state == BUS_IDLE) begin
            avs_readdata_o <= hit ? {24'h00_0000, status_byte} : UNMAPPED_READ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pull device: pull-down when looking for rising, pull-up for falling
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pull_up_en_o   <= 1'b0;
            pull_down_en_o <= 1'b0;
        end else begin
            pull_up_en_o   <= request_pin_enable && !pull_device_disable && !edge_polarity_select;
            pull_down_en_o <= request_pin_enable && !pull_device_disable && edge_polarity_select;
        end
    end

    // Processor request follows the flag while enabled
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_request_o <= 1'b0;
        end else begin
            cpu_request_o <= request_interrupt_enable && cfg.flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Detector for the pin
    pin_event_detect u_detect (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (request_pin_i),
        .cfg       (cfg.detect)
    );

endmodule : pin_request_top
`default_nettype wire

// ---- pin_request_props.sv ----
// Port-level checker for the pin request block
`timescale 1ns/10ps
`default_nettype none
module pin_request_props
    import pin_request_pkg::*;
(
    // Clock, reset and bus
    input wire logic              mclk_i,
    input wire logic              reset_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0]        avs_byteenable_i,
    input wire logic [DATA_W-1:0] avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    // Pin and request
    input wire logic              request_pin_i,
    input wire logic              pull_up_en_o,
    input wire logic              pull_down_en_o,
    input wire logic              cpu_request_o
);
    logic       wr_take;
    logic       rd_take;
    logic [7:0] cfg;
    logic [3:0] held;
    assign wr_take = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0];
    assign rd_take = avs_read_i && !avs_waitrequest_o && avs_address_i == 4'h0;
    // Shadow of the register, taken where the block accepts a write
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg <= 8'h00;
        end else if (wr_take) begin
            cfg <= avs_writedata_i[7:0];
        end
    end
    // Cycles the pin sat asserted in level mode; saturates so it never wraps
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            held <= 4'h0;
        end else begin
            held <= (cfg[4] && cfg[0] && request_pin_i == cfg[5]) ? held + {3'h0, held != 4'hF} : 4'h0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_one_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state length wrong");
    property p_pull_up; $stable(cfg) |-> pull_up_en_o == (cfg[4] && !cfg[6] && !cfg[5]); endproperty
    a_pull_up: assert property (p_pull_up) else $error("pull-up wrong");
    property p_pull_down; $stable(cfg) |-> pull_down_en_o == (cfg[4] && !cfg[6] && cfg[5]); endproperty
    a_pull_down: assert property (p_pull_down) else $error("pull-down wrong");
    property p_read_image;
        rd_take |-> avs_readdata_o[31:7] == 25'h0 && !avs_readdata_o[2]
            && {avs_readdata_o[6:4], avs_readdata_o[1:0]} == {cfg[6:4], cfg[1:0]};
    endproperty
    a_read_image: assert property (p_read_image) else $error("read image wrong");
    property p_cpu_gate; cpu_request_o |-> cfg[1] || $past(cfg[1]); endproperty
    a_cpu_gate: assert property (p_cpu_gate) else $error("request while disabled");
    property p_edge_set; cfg[4] && cfg[1] && !cfg[5] && !cfg[0] && $fell(request_pin_i) |-> ##[3:10] cpu_request_o; endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not flagged");
    property p_level_hold; held == 4'hF && cfg[1] |-> cpu_request_o; endproperty
    a_level_hold: assert property (p_level_hold) else $error("level not held");
    property p_ack_clear; wr_take && avs_writedata_i[2] && !avs_writedata_i[0] && !cfg[0] |-> ##2 !cpu_request_o; endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack did not clear");
    c_level: cover property (held == 4'hF && cfg[1]);
    c_ack: cover property (wr_take && avs_writedata_i[2]);
    c_request: cover property (cpu_request_o);
endmodule : pin_request_props
`default_nettype wire

// ---- ext_pin_device.sv ----
// Model of the external device driving the request pin
`timescale 1ns/10ps
`default_nettype none
module ext_pin_device (
    // Clock, drive control and pull state
    input  wire logic mclk_i,
    input  wire logic drive_i,
    input  wire logic level_i,
    input  wire logic pull_up_en_i,
    input  wire logic pull_down_en_i,
    output logic      pin_o
);
    logic wobble = 1'b0;
    // A released pin with no pull wanders, so no neat value hides a fault
    always @(posedge mclk_i) begin
        wobble <= !wobble;
    end
    // Driven level, else the pull that the block applies
    assign pin_o = drive_i ? level_i : pull_up_en_i ? 1'b1 : pull_down_en_i ? 1'b0 : wobble;
endmodule : ext_pin_device
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the pin request block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pin_request_pkg::*;
    logic              mclk_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = 4'h0;
    logic [DATA_W-1:0] avs_writedata_i = 32'h0;
    logic [3:0]        avs_byteenable_i = 4'h1;
    logic [DATA_W-1:0] avs_readdata_o;
    logic              avs_waitrequest_o, request_pin_i, pull_up_en_o, pull_down_en_o, cpu_request_o;
    logic              drive = 1'b1;
    logic              level = 1'b1;
    logic [7:0]        cw [5] = '{8'h10, 8'h30, 8'h70, 8'hDC, 8'h00};
    logic [7:0]        cr [5] = '{8'h10, 8'h30, 8'h70, 8'h50, 8'h00};
    logic [1:0]        cp [5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
    int                num_errors = 0;
    int                samples_checked = 0;
    // Bus clock
    always #5 mclk_i = !mclk_i;
    pin_request_top u_dut (.mclk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .request_pin_i, .pull_up_en_o, .pull_down_en_o,
        .cpu_request_o);
    ext_pin_device u_dev (.mclk_i, .drive_i(drive), .level_i(level), .pull_up_en_i(pull_up_en_o),
        .pull_down_en_i(pull_down_en_o), .pin_o(request_pin_i));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Request held until waitrequest is seen low at a rising edge; data taken at that same edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        logic w;
        avs_address_i   <= a;
        avs_writedata_i <= {24'h0, d};
        avs_write_i     <= wr;
        avs_read_i      <= !wr;
        do begin
            @(posedge mclk_i);
            w = avs_waitrequest_o;
            q = avs_readdata_o;
        end while (w !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        @(posedge mclk_i);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        check(q & m, e);
    endtask : rchk
    // Pin level then a settle time well past the six-edge path to the request
    task automatic pin(input logic l);
        level <= l;
        repeat (12) @(posedge mclk_i);
    endtask : pin
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(4'h0, cw[i]);
            rchk(4'h0, 32'hFFFF_FFF7, {24'h0, cr[i]});
            check({30'h0, pull_up_en_o, pull_down_en_o}, {30'h0, cp[i]});
        end
        $display("test config done");
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h0);
        pin(1'b1);
        wr(4'h0, 8'h14);
        pin(1'b1);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h10);
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h18);
        check({31'h0, cpu_request_o}, 32'h0);
        wr(4'h0, 8'h16);
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h12);
        pin(1'b1);
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h1A);
        check({31'h0, cpu_request_o}, 32'h1);
        wr(4'h0, 8'h12);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h1A);
        wr(4'h0, 8'h16);
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h12);
        check({31'h0, cpu_request_o}, 32'h0);
        $display("test edge done");
        wr(4'h0, 8'h17);
        pin(1'b0);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h1B);
        wr(4'h0, 8'h17);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h1B);
        pin(1'b1);
        wr(4'h0, 8'h17);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h13);
        wr(4'h0, 8'h37);
        pin(1'b1);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h3B);
        check({31'h0, cpu_request_o}, 32'h1);
        drive <= 1'b0;
        pin(1'b1);
        wr(4'h0, 8'h37);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h33);
        $display("test level done");
        rchk(4'h4, 32'hFFFF_FFFF, 32'h0);
        wr(4'h4, 8'h00);
        avs_byteenable_i <= 4'h0;
        wr(4'h0, 8'h00);
        avs_byteenable_i <= 4'h1;
        rchk(4'h0, 32'hFFFF_FFFF, 32'h33);
        // Second reset in mid-run: register and flag must come back clear
        reset_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        rchk(4'h0, 32'hFFFF_FFFF, 32'h0);
        check({30'h0, pull_up_en_o, pull_down_en_o}, 32'h0);
        $display("test bus done");
        end_sim();
    end
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (5000) @(posedge mclk_i);
        num_errors++;
        end_sim();
    end
endmodule : tb
bind pin_request_top pin_request_props u_props (.mclk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .request_pin_i, .pull_up_en_o,
    .pull_down_en_o, .cpu_request_o);
`default_nettype wire
